// >>> rtl/pgd_pkg.sv
// Shared types and constants for the predicated execution guard
package pgd_pkg;

  // ==========================================================================
  // Predicate file geometry and reset state
  localparam int          PGD_NPRED     = 64;
  localparam int          PGD_QPW       = 6;
  localparam int          PGD_TRUE_IDX  = 0;
  localparam logic [63:0] PGD_PRED_RST  = 64'h0000_0000_0000_0001;

  // ==========================================================================
  // Instruction classes seen by the guard
  typedef enum logic [3:0] {
    PGD_OP_NOP,
    PGD_OP_ALU,
    PGD_OP_LOAD,
    PGD_OP_STORE,
    PGD_OP_CMP,
    PGD_OP_CMP_UNC,
    PGD_OP_TBIT,
    PGD_OP_FCMP,
    PGD_OP_APPROX,
    PGD_OP_BRANCH
  } pgd_op_t;

  // ==========================================================================
  // One issued instruction, with its execute-stage outcome bit
  typedef struct packed {
    logic                 valid;
    pgd_op_t              op;
    logic [PGD_QPW-1:0]   qp;
    logic [PGD_QPW-1:0]   pd1;
    logic [PGD_QPW-1:0]   pd2;
    logic                 res;
    logic                 stop;
  } pgd_issue_t;

  // ==========================================================================
  // Architectural effects granted to the instruction
  typedef struct packed {
    logic valid;
    logic squash;
    logic reg_we;
    logic mem_rd;
    logic mem_wr;
    logic fault_en;
    logic cache_en;
    logic br_taken;
  } pgd_commit_t;

endpackage

// >>> rtl/pgd_pred_file.sv
// Predicate register file with a stop-boundary snapshot
`timescale 1ns/1ps
module pgd_pred_file import pgd_pkg::*; #(
  parameter int NPRED = PGD_NPRED
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Pair write
  input  wire logic                 we1,
  input  wire logic [PGD_QPW-1:0]   idx1,
  input  wire logic                 d1,
  input  wire logic                 we2,
  input  wire logic [PGD_QPW-1:0]   idx2,
  input  wire logic                 d2,
  // Take snapshot after this cycle's writes
  input  wire logic                 snap_en,
  // State
  output logic      [NPRED-1:0]     pr_live,
  output logic      [NPRED-1:0]     pr_snap
);

  logic [NPRED-1:0] next_pr;

  // Every index value must land on a real predicate
  if (NPRED != (1 << PGD_QPW)) begin : g_chk
    $error("pgd_pred_file: NPRED must match the index width");
  end

  // ==========================================================================
  // Write merge; the true predicate drops every write
  always_comb begin
    next_pr = pr_live;
    if (we1) begin
      next_pr[idx1] = d1;
    end
    if (we2) begin
      next_pr[idx2] = d2;
    end
    next_pr[PGD_TRUE_IDX] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pr_live <= PGD_PRED_RST[NPRED-1:0];
      pr_snap <= PGD_PRED_RST[NPRED-1:0];
    end else begin
      pr_live <= next_pr;
      if (snap_en) begin
        pr_snap <= next_pr;
      end
    end
  end

endmodule

// >>> rtl/pgd_guard.sv
// Qualifying-predicate guard: commits or squashes each issued instruction
//
// How it works
// - every instruction names a guarding predicate selected by its qp field
// - a false guard removes every effect but the unconditional predicate writes below, a plain no-op
// - a true guard grants exactly the effects of an unguarded instruction
// - unconditional compares and approximations write predicates when false
// - compares and bit tests write a predicate pair from outcome or bit
// - integer compare or test feeds a branch in the same group
// - complementary pair from one compare, neither target predicate zero, never lets both consumers act
// - a false-guarded store raises no fault and leaves memory untouched
// - false-guarded loads and stores never touch the cache
`timescale 1ns/1ps
module pgd_guard import pgd_pkg::*; #(
  parameter int NPRED = PGD_NPRED
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Issue side
  input  wire pgd_issue_t           iss,
  // Commit side
  output pgd_commit_t               commit,
  output logic      [NPRED-1:0]     pred
);

  // ==========================================================================
  // Elaboration checks
  if (NPRED != PGD_NPRED || NPRED != (1 << PGD_QPW)) begin : g_chk
    $error("pgd_guard: NPRED must equal the package predicate count");
  end

  // ==========================================================================
  // Predicate file
  logic [NPRED-1:0] pr_live;
  logic [NPRED-1:0] pr_snap;
  logic [NPRED-1:0] grp_fp;
  logic [NPRED-1:0] next_grp_fp;
  pgd_commit_t      next_commit;

  wire logic op_alu    = (iss.op == PGD_OP_ALU);
  wire logic op_load   = (iss.op == PGD_OP_LOAD);
  wire logic op_store  = (iss.op == PGD_OP_STORE);
  wire logic op_unc    = (iss.op == PGD_OP_CMP_UNC);
  wire logic op_fcmp   = (iss.op == PGD_OP_FCMP);
  wire logic op_approx = (iss.op == PGD_OP_APPROX);
  wire logic op_branch = (iss.op == PGD_OP_BRANCH);
  wire logic op_icmp   = (iss.op == PGD_OP_CMP) || op_unc ||
                         (iss.op == PGD_OP_TBIT);
  wire logic op_mem    = op_load || op_store;

  // Ordinary consumers see the state as of the last stop; a branch sees
  // live integer-compare results, but never a same-group fp compare
  wire logic guard_snap = pr_snap[iss.qp];
  wire logic guard_live = pr_live[iss.qp];
  wire logic use_live   = op_branch && !grp_fp[iss.qp];
  wire logic guard      = use_live ? guard_live : guard_snap;
  wire logic exec       = iss.valid && guard;

  // Pair writes; unconditional forms clear their targets when false
  wire logic cmp_any = op_icmp || op_fcmp;
  wire logic pred_only = op_unc || op_approx;
  wire logic pw1     = iss.valid &&
                       ((cmp_any && guard) || op_unc || op_approx);
  wire logic pw2     = pw1 && !op_approx;
  wire logic pd1_val = guard && iss.res;
  wire logic pd2_val = guard && !iss.res;

  pgd_pred_file #(
    .NPRED (NPRED)
  ) u_pf (
    .clk     (clk),
    .rstn    (rstn),
    .we1     (pw1),
    .idx1    (iss.pd1),
    .d1      (pd1_val),
    .we2     (pw2),
    .idx2    (iss.pd2),
    .d2      (pd2_val),
    .snap_en (iss.valid && iss.stop),
    .pr_live (pr_live),
    .pr_snap (pr_snap)
  );

  // ==========================================================================
  // Group tracking of fp compare targets, cleared at each stop
  always_comb begin
    next_grp_fp = grp_fp;
    if (iss.valid && iss.stop) begin
      next_grp_fp = '0;
    end else if (pw1 && op_fcmp) begin
      next_grp_fp[iss.pd1] = 1'b1;
      next_grp_fp[iss.pd2] = 1'b1;
    end
  end

  // ==========================================================================
  // Commit decision
  always_comb begin
    next_commit          = '0;
    next_commit.valid    = iss.valid;
    // Squash follows the guard except for unconditional compares and approximations, so a false-guarded nop is squashed too
    next_commit.squash   = iss.valid && !guard && !pred_only;
    next_commit.reg_we   = exec && (op_alu || op_load || op_approx);
    next_commit.mem_rd   = exec && op_load;
    next_commit.mem_wr   = exec && op_store;
    next_commit.fault_en = exec && op_mem;
    next_commit.cache_en = exec && op_mem;
    next_commit.br_taken = exec && op_branch;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      commit <= '0;
      grp_fp <= '0;
    end else begin
      commit <= next_commit;
      grp_fp <= next_grp_fp;
    end
  end

  assign pred = pr_live;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_false_store;
    iss.valid && op_store && !guard;
  endsequence

  sequence s_store_silent;
    !commit.mem_wr && !commit.fault_en && !commit.cache_en && commit.squash;
  endsequence

  AST_TRUE_PRED: assert property (
    pr_live[PGD_TRUE_IDX] && pr_snap[PGD_TRUE_IDX])
    else $error("predicate zero not true");

  AST_STORE_SQUASH: assert property (s_false_store |=> s_store_silent)
    else $error("false-guarded store had an effect");

  AST_LOAD_CACHE: assert property (
    iss.valid && op_load && !guard |=> !commit.cache_en && !commit.mem_rd)
    else $error("false-guarded load touched cache");

  AST_NOP: assert property (
    iss.valid && op_alu && !guard |=> !commit.reg_we && commit.squash)
    else $error("false-guarded op wrote a register");

  AST_EXEC: assert property (
    iss.valid && op_load && guard |=> commit.reg_we && commit.mem_rd
                                      && !commit.squash)
    else $error("true-guarded load lost an effect");

  AST_CMP_VAL: assert property (
    iss.valid && op_icmp && guard && iss.pd1 != 0 && iss.pd1 != iss.pd2
      |=> pr_live[$past(iss.pd1)] == $past(iss.res))
    else $error("compare target has wrong value");

  AST_PAIR: assert property (
    iss.valid && cmp_any && guard && iss.pd1 != iss.pd2 &&
    iss.pd1 != 0 && iss.pd2 != 0
      |=> pr_live[$past(iss.pd1)] != pr_live[$past(iss.pd2)])
    else $error("complementary predicates agree");

  AST_UNC: assert property (
    iss.valid && op_unc && !guard && iss.pd1 != 0
      |=> !pr_live[$past(iss.pd1)])
    else $error("unconditional compare did not clear");

  AST_FWD: assert property (
    iss.valid && op_branch && !grp_fp[iss.qp]
      |=> commit.br_taken == $past(guard_live))
    else $error("branch missed forwarded predicate");

  AST_GROUP: assert property (
    iss.valid && op_alu |=> commit.reg_we == $past(guard_snap))
    else $error("consumer read predicate inside its group");

  // Equal targets: the second write wins, so the first check skips them
  AST_SAME_PAIR: assert property (
    iss.valid && cmp_any && guard && iss.pd1 == iss.pd2 && iss.pd2 != 0
      |=> pr_live[$past(iss.pd2)] == !$past(iss.res))
    else $error("second compare target did not win");

  AST_CMP_KEEP: assert property (
    iss.valid && cmp_any && !op_unc && !guard |=> pr_live == $past(pr_live))
    else $error("false-guarded compare wrote a predicate");

  AST_APPROX: assert property (
    iss.valid && op_approx && iss.pd1 != 0
      |=> pr_live[$past(iss.pd1)] == $past(guard && iss.res))
    else $error("approximation status predicate wrong");

  AST_STORE_EXEC: assert property (
    iss.valid && op_store && guard |=> commit.mem_wr && commit.fault_en
      && commit.cache_en && !commit.squash)
    else $error("true-guarded store lost an effect");

  AST_SNAP: assert property (
    iss.valid && iss.stop |=> pr_snap == pr_live)
    else $error("stop did not refresh the group view");

  AST_FCMP_MARK: assert property (
    iss.valid && op_fcmp && guard && !iss.stop
      |=> grp_fp[$past(iss.pd1)] && grp_fp[$past(iss.pd2)])
    else $error("fp compare target not held back from branches");

  // A false guard leaves only the squash flag, for every class but unconditional compares and approximations
  sequence s_no_effect;
    commit.squash && !commit.reg_we && !commit.mem_rd && !commit.mem_wr &&
    !commit.fault_en && !commit.cache_en && !commit.br_taken;
  endsequence

  AST_FALSE_QUIET: assert property (
    iss.valid && !guard && !pred_only |=> s_no_effect)
    else $error("false-guarded instruction had an effect");

  AST_IDLE: assert property (!iss.valid |=> commit == '0)
    else $error("commit raised without an instruction");

endmodule

// >>> verification/pgd_stream.sv
// Instruction stream model: inserts stops and notes expected outcomes
`timescale 1ns/1ps
module pgd_stream import pgd_pkg::*; (
  // Clock
  input  wire logic  clk,
  // Issue side
  output pgd_issue_t iss
);
  // ========================================================
  // Reference predicate file and per-group writer tracking
  logic        [63:0] mp;
  logic        [63:0] wgrp;
  logic        [63:0] fgrp;
  pgd_commit_t        exp_c[$];
  logic        [63:0] exp_p[$];

  initial iss = '0;

  task automatic restart();
    mp = PGD_PRED_RST;
    wgrp = '0;
    fgrp = '0;
  endtask

  // Idle fields toggle so nothing can lean on stale values
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      iss <= {1'b0, ~iss[$bits(pgd_issue_t)-2:0]};
    end
  endtask

  task automatic put(input pgd_issue_t i);
    pgd_commit_t c;
    logic        g;
    logic        wr;
    @(negedge clk);
    iss <= i;
    g = mp[i.qp];
    wr = i.op inside {PGD_OP_CMP, PGD_OP_TBIT, PGD_OP_FCMP, PGD_OP_CMP_UNC};
    c = '0;
    c.valid = 1'b1;
    c.squash = !g && !(i.op inside
      {PGD_OP_CMP_UNC, PGD_OP_APPROX});
    c.reg_we = g && (i.op inside
      {PGD_OP_ALU, PGD_OP_LOAD, PGD_OP_APPROX});
    c.mem_rd = g && i.op == PGD_OP_LOAD;
    c.mem_wr = g && i.op == PGD_OP_STORE;
    c.fault_en = g && (i.op inside {PGD_OP_LOAD, PGD_OP_STORE});
    c.cache_en = c.fault_en;
    c.br_taken = g && i.op == PGD_OP_BRANCH;
    if (wr && (g || i.op == PGD_OP_CMP_UNC)) begin
      mp[i.pd1] = g & i.res;
      mp[i.pd2] = g & ~i.res;
    end
    if (i.op == PGD_OP_APPROX) mp[i.pd1] = g & i.res;
    mp[PGD_TRUE_IDX] = 1'b1;
    exp_c.push_back(c);
    exp_p.push_back(mp);
    if (i.stop) begin
      wgrp = '0;
      fgrp = '0;
    end else if (wr || i.op == PGD_OP_APPROX) begin
      wgrp[i.pd1] = 1'b1;
      if (wr) wgrp[i.pd2] = 1'b1;
      // Over-marking only costs an extra stop, never a wrong guard
      if (i.op == PGD_OP_FCMP) fgrp = fgrp | wgrp;
    end
  endtask

  task automatic issue(input pgd_issue_t i);
    if (fgrp[i.qp] || (wgrp[i.qp] && i.op != PGD_OP_BRANCH)) begin
      put('{1'b1, PGD_OP_NOP, 6'h0, 6'h0, 6'h0, 1'b0, 1'b1});
    end
    put(i);
  endtask
endmodule

// >>> verification/tb_pgd_guard.sv
// Self-checking bench for the predicated execution guard
`timescale 1ns/1ps
module tb_pgd_guard import pgd_pkg::*;;
  // ========================================================
  // Harness
  logic        clk;
  logic        rstn;
  pgd_issue_t  iss;
  pgd_commit_t commit;
  logic [63:0] pred;
  pgd_commit_t ec;
  logic [63:0] ep;
  int          mismatches;
  int          tests_run;

  pgd_stream i_src (.clk(clk), .iss(iss));
  pgd_guard i_dut (.clk(clk), .rstn(rstn), .iss(iss), .commit(commit),
                   .pred(pred));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic check(input string w, input logic [63:0] e, x);
    tests_run++;
    if (x !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", w, e, x);
    end
  endtask

  task automatic complete_run();
    check("pending", 64'h0, 64'(i_src.exp_c.size()));
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk);
    rstn <= 1'b0;
    i_src.restart();
    repeat (6) @(negedge clk);
    rstn <= 1'b1;
    check("reset pred", PGD_PRED_RST, pred);
    check("reset commit", 64'h0, 64'(commit));
  endtask

  task automatic mk(input pgd_op_t o, input logic [5:0] q, a, b,
                    input logic r, s);
    i_src.issue('{1'b1, o, q, a, b, r, s});
  endtask

  // Narrow index range makes guards and targets collide often
  task automatic rnd(input int n);
    repeat (n) begin
      mk(pgd_op_t'(4'($urandom % 10)), 6'($urandom % 8),
         6'($urandom % 8), 6'($urandom % 8),
         1'($urandom % 2), 1'($urandom % 4 == 0));
    end
  endtask

  // ========================================================
  // Result watcher
  always @(negedge clk) begin
    if (rstn && commit.valid === 1'b1) begin
      if (i_src.exp_c.size() == 0) begin
        check("extra commit", 64'h0, 64'h1);
      end else begin
        ec = i_src.exp_c.pop_front();
        ep = i_src.exp_p.pop_front();
        check("commit", 64'(ec), 64'(commit));
        check("pred", ep, pred);
      end
    end
  end

  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(7073));
    do_reset();
    mk(PGD_OP_CMP, 6'h0, 6'h0, 6'h1, 1'b1, 1'b0);
    mk(PGD_OP_CMP, 6'h0, 6'h2, 6'h3, 1'b1, 1'b0);
    mk(PGD_OP_BRANCH, 6'h2, 6'h0, 6'h0, 1'b0, 1'b0);
    mk(PGD_OP_BRANCH, 6'h3, 6'h0, 6'h0, 1'b0, 1'b0);
    mk(PGD_OP_CMP, 6'h0, 6'h7, 6'h7, 1'b1, 1'b1);
    for (int o = 0; o < 10; o++) begin
      mk(pgd_op_t'(4'(o)), 6'h2, 6'(8 + o), 6'(20 + o), o[0], 1'b0);
      mk(pgd_op_t'(4'(o)), 6'h3, 6'(8 + o), 6'(20 + o), o[0], 1'b1);
    end
    rnd(400);
    i_src.idle(3);
    do_reset();
    rnd(60);
    i_src.idle(3);
    complete_run();
  end
endmodule
